// ==== rtl/gcq_lane_mem.sv ====
// Per-lane transmitter settings store, one word per lane of a quad
module gcq_lane_mem
(
	input  wire logic                        clk,       // Core clock
	input  wire logic                        rst,       // Async reset
	input  wire logic                        wr_en,     // Write strobe
	input  wire logic [1:0]                  wr_lane,   // Lane written
	input  wire logic [gcq_pkg::LANE_W-1:0]  wr_data,   // New lane settings
	output logic [4*gcq_pkg::LANE_W-1:0]     rd_data    // All lanes, registered
);

	logic [gcq_pkg::LANE_W-1:0] mem_reg  [4];
	logic [gcq_pkg::LANE_W-1:0] mem_next [4];

	// Write takes effect immediately, no link state gates it
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			mem_next[i] = mem_reg[i];
			if (wr_en && (wr_lane == 2'(i)))
				mem_next[i] = wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 4; i++)
				mem_reg[i] <= {gcq_pkg::DRV_RESET, gcq_pkg::BOOST_RESET,
					gcq_pkg::DEA_RESET, gcq_pkg::SLEW_RESET};
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				mem_reg[i] <= mem_next[i];
		end
	end

	// Registered read of every lane
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			rd_data[i*gcq_pkg::LANE_W +: gcq_pkg::LANE_W] = mem_reg[i];
	end

endmodule // gcq_lane_mem

// ==== rtl/gcq_pkg.sv ====
package gcq_pkg;

	// Port and quad numbering
	localparam int          NUM_QUADS      = 14;
	localparam int          LANES_PER_QUAD = 4;
	localparam logic [3:0]  QUAD_GAP_LO    = 4'hA;
	localparam logic [3:0]  QUAD_GAP_HI    = 4'hB;

	// Symbol 4 bit positions carrying newer meanings
	localparam int          SYM4_RATE_BIT  = 2;
	localparam int          SYM4_MULTI_BIT = 6;
	localparam int          SYM4_SPEED_BIT = 7;
	localparam logic [7:0]  SYM4_NEW_MASK  = 8'hC4;

	// Amplitude boost encoding, four increasing steps
	localparam logic [1:0]  BOOST_RESET    = 2'h1;

	// Per-lane setting widths
	localparam int          DRV_W          = 5;
	localparam int          DEA_W          = 5;
	localparam int          SLEW_W         = 4;
	localparam int          LANE_W         = DRV_W + 2 + DEA_W + SLEW_W;
	localparam logic [4:0]  DRV_RESET      = 5'h10;
	localparam logic [4:0]  DEA_RESET      = 5'h00;
	localparam logic [3:0]  SLEW_RESET     = 4'h8;

	// De-emphasis levels driven to the transmitter
	localparam logic [1:0]  DEEMPH_3P5DB   = 2'h0;
	localparam logic [1:0]  DEEMPH_6DB     = 2'h1;
	localparam logic [1:0]  DEEMPH_0DB     = 2'h2;

	// Training mode state encodings
	typedef enum logic [2:0]
	{
		GCQ_NATIVE    = 3'h1,
		GCQ_RETRAIN   = 3'h2,
		GCQ_COMPAT    = 3'h4
	} gcq_mode_type;

endpackage

// ==== rtl/gcq_port_phy.sv ====
// Notes on behaviour
// - Compatibility mode is entered only by setting the enable and then requesting a full retrain.
// - In compatibility mode symbol 4 bits 2, 6 and 7 of every sent TS1 and TS2 are cleared.
// - Clearing the enable and retraining leaves compatibility mode, restoring those bits' meanings.
// - Twelve quads numbered 0 to 13 exist, 10 and 11 absent, each serving its own port.
// - A four-lane port always uses the quad whose number equals the port number.
// - A merged eight-lane port of an even and next odd port uses both those quads.
// - Amplitude boost has four increasing settings and resets to the second.
// - Low-swing forces 0 dB de-emphasis and ignores the selectable de-emphasis bit.
// - Low-swing applies per link, all lanes of the port switch together.
// - Lane drive, boost, de-emphasis adjust and slew update at any time without retrain.
module gcq_port_phy
(
	input  wire logic                        clk,                  // Core clock
	input  wire logic                        rst,                  // Async reset
	input  wire logic [3:0]                  port_num,             // This port's number
	input  wire logic                        merged_x8,            // Port merged with odd partner
	input  wire logic                        legacy_compat_enable, // Compat enable bit
	input  wire logic                        full_retrain_request, // Full retrain pulse
	input  wire logic                        retrain_done,         // Link retrain finished pulse
	input  wire logic                        low_swing,            // Link low-swing mode
	input  wire logic                        sel_deemph_6db,       // Selectable de-emphasis
	input  wire logic                        ts_valid,             // Training set symbol valid
	input  wire logic [3:0]                  ts_sym_idx,           // Symbol index in set
	input  wire logic [7:0]                  ts_sym_in,            // Symbol from LTSSM
	input  wire logic                        lane_wr_en,           // Lane setting write
	input  wire logic [1:0]                  lane_wr_lane,         // Lane within the quad written
	input  wire logic                        lane_wr_hi_quad,      // Write to the odd quad
	input  wire logic [gcq_pkg::LANE_W-1:0]  lane_wr_data,         // Drive/boost/deemph/slew
	output logic                             ts_valid_out,         // Symbol valid to link
	output logic [7:0]                       ts_sym_out,           // Symbol to link
	output logic                             compat_active,        // Compat mode in force
	output logic                             retrain_busy,         // Retrain in progress
	output logic [gcq_pkg::NUM_QUADS-1:0]    quad_sel,             // Quads used by port
	output logic                             port_valid,           // Port number exists
	output logic [1:0]                       deemph_level,         // De-emphasis to drivers
	output logic [7:0]                       lane_low_swing,       // Low-swing per lane
	output logic [8*gcq_pkg::LANE_W-1:0]     lane_settings         // Settings, eight lanes
);

	////////////////////////////////////////////////////////////////
	// Helper functions

	// Quads 10 and 11 are not fitted
	function automatic logic quad_exists(input logic [3:0] q);
		quad_exists = (q < 4'(gcq_pkg::NUM_QUADS)) && (q != gcq_pkg::QUAD_GAP_LO)
			&& (q != gcq_pkg::QUAD_GAP_HI);
	endfunction

	function automatic logic [gcq_pkg::NUM_QUADS-1:0] quad_bit(input logic [3:0] q);
		quad_bit = quad_exists(q) ? (gcq_pkg::NUM_QUADS'(1) << q) : '0;
	endfunction

	////////////////////////////////////////////////////////////////
	// Compat mode state machine

	gcq_pkg::gcq_mode_type mode_reg, mode_next;
	logic                  target_compat_reg, target_compat_next;

	// Enable bit only sampled on a full retrain request
	always_comb
	begin
		mode_next          = mode_reg;
		target_compat_next = target_compat_reg;
		case (mode_reg)
			gcq_pkg::GCQ_NATIVE,
			gcq_pkg::GCQ_COMPAT:
			begin
				if (full_retrain_request)
				begin
					target_compat_next = legacy_compat_enable;
					mode_next          = gcq_pkg::GCQ_RETRAIN;
				end
			end
			gcq_pkg::GCQ_RETRAIN:
			begin
				if (retrain_done)
					mode_next = target_compat_reg ? gcq_pkg::GCQ_COMPAT
						: gcq_pkg::GCQ_NATIVE;
			end
			default:
				mode_next = gcq_pkg::GCQ_NATIVE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mode_reg          <= gcq_pkg::GCQ_NATIVE;
			target_compat_reg <= 1'b0;
		end
		else
		begin
			mode_reg          <= mode_next;
			target_compat_reg <= target_compat_next;
		end
	end

	// Training sets of the retrain already use the new setting
	logic strip_bits;
	assign strip_bits    = (mode_reg == gcq_pkg::GCQ_RETRAIN) ? target_compat_reg
		: (mode_reg == gcq_pkg::GCQ_COMPAT);
	assign compat_active = (mode_reg == gcq_pkg::GCQ_COMPAT);
	assign retrain_busy  = (mode_reg == gcq_pkg::GCQ_RETRAIN);

	////////////////////////////////////////////////////////////////
	// Training set symbol filter

	logic       ts_valid_reg, ts_valid_next;
	logic [7:0] ts_sym_reg, ts_sym_next;

	// Symbol 4 newer bits cleared in compat mode and in a retrain into it, passed otherwise
	always_comb
	begin
		ts_valid_next = ts_valid;
		ts_sym_next   = ts_sym_in;
		if (ts_valid && (ts_sym_idx == 4'h4) && strip_bits)
			ts_sym_next = ts_sym_in & ~gcq_pkg::SYM4_NEW_MASK;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ts_valid_reg <= 1'b0;
			ts_sym_reg   <= 8'h00;
		end
		else
		begin
			ts_valid_reg <= ts_valid_next;
			ts_sym_reg   <= ts_sym_next;
		end
	end

	assign ts_valid_out = ts_valid_reg;
	assign ts_sym_out   = ts_sym_reg;

	////////////////////////////////////////////////////////////////
	// Quad mapping and transmitter levels

	logic [3:0]                   hi_quad;
	logic [gcq_pkg::NUM_QUADS-1:0] quad_sel_next, quad_sel_reg;
	logic [1:0]                   deemph_next, deemph_reg;
	logic [7:0]                   swing_next, swing_reg;

	// Merged port pairs even quad with next odd one
	assign hi_quad = {port_num[3:1], 1'b1};

	always_comb
	begin
		quad_sel_next = quad_bit(port_num);
		if (merged_x8 && !port_num[0])
			quad_sel_next = quad_bit(port_num) | quad_bit(hi_quad);
		if (low_swing)
			deemph_next = gcq_pkg::DEEMPH_0DB;
		else
			deemph_next = sel_deemph_6db ? gcq_pkg::DEEMPH_6DB : gcq_pkg::DEEMPH_3P5DB;
		// All lanes of the link follow one bit, merged or not
		swing_next = merged_x8 ? {8{low_swing}} : {4'h0, {4{low_swing}}};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			quad_sel_reg <= '0;
			deemph_reg   <= gcq_pkg::DEEMPH_3P5DB;
			swing_reg    <= 8'h00;
		end
		else
		begin
			quad_sel_reg <= quad_sel_next;
			deemph_reg   <= deemph_next;
			swing_reg    <= swing_next;
		end
	end

	assign quad_sel       = quad_sel_reg;
	assign port_valid     = quad_exists(port_num);
	assign deemph_level   = deemph_reg;
	assign lane_low_swing = swing_reg;

	////////////////////////////////////////////////////////////////
	// Per-lane settings, two quads

	logic wr_lo, wr_hi;

	// No retrain gating so updates apply live
	assign wr_lo = lane_wr_en && !lane_wr_hi_quad;
	assign wr_hi = lane_wr_en && lane_wr_hi_quad && merged_x8;

	// Reset boost is the second of four steps
	gcq_lane_mem u_mem_lo
	(
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_lo),
		.wr_lane (lane_wr_lane),
		.wr_data (lane_wr_data),
		.rd_data (lane_settings[4*gcq_pkg::LANE_W-1:0])
	);

	gcq_lane_mem u_mem_hi
	(
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_hi),
		.wr_lane (lane_wr_lane),
		.wr_data (lane_wr_data),
		.rd_data (lane_settings[8*gcq_pkg::LANE_W-1:4*gcq_pkg::LANE_W])
	);

endmodule // gcq_port_phy

// ==== testbench/gcq_checker_sva.sv ====
module gcq_checker_sva
(
	input wire logic        clk,                  // Core clock
	input wire logic        rst,                  // Async reset
	input wire logic [3:0]  port_num,             // Port number
	input wire logic        merged_x8,            // Merged x8
	input wire logic        full_retrain_request, // Retrain pulse
	input wire logic        retrain_done,         // Retrain done
	input wire logic        low_swing,            // Low swing
	input wire logic        ts_valid,             // Symbol valid
	input wire logic [3:0]  ts_sym_idx,           // Symbol index
	input wire logic [7:0]  ts_sym_in,            // Symbol in
	input wire logic [7:0]  ts_sym_out,           // Symbol out
	input wire logic        compat_active,        // Compat mode
	input wire logic        retrain_busy,         // Retraining
	input wire logic [13:0] quad_sel,             // Quads used
	input wire logic        port_valid,           // Port exists
	input wire logic [1:0]  deemph_level          // De-emphasis
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// A request outside a retrain starts one
	sequence s_req;
		full_retrain_request && !retrain_busy;
	endsequence
	AST_RETRAIN: assert property (s_req |=> retrain_busy)
		else $error("retrain not started");
	// Mode enters only at the end of a retrain, never on the enable alone
	AST_MODE_HOLD: assert property ($rose(compat_active) |-> $past(retrain_done))
		else $error("mode entered without retrain");
	// Mode is left only by a retrain request, which drops the flag while retraining
	AST_MODE_LEAVE: assert property ($fell(compat_active) |-> $past(full_retrain_request))
		else $error("mode left without retrain");
	AST_STRIP: assert property (compat_active && !full_retrain_request && ts_valid
		&& ts_sym_idx == 4'h4 |=> (ts_sym_out & gcq_pkg::SYM4_NEW_MASK) == 8'h00)
		else $error("new bits sent in compat mode");
	AST_PASS: assert property (!compat_active && !retrain_busy && !full_retrain_request
		&& ts_valid |=> ts_sym_out == $past(ts_sym_in))
		else $error("native symbol altered");
	AST_X4: assert property (!merged_x8 |=> quad_sel ==
		($past(port_valid) ? 14'h0001 << $past(port_num) : 14'h0000))
		else $error("x4 quad wrong");
	AST_X8: assert property (merged_x8 && !port_num[0] && port_valid
		|=> quad_sel == 14'h0003 << $past(port_num))
		else $error("x8 quads wrong");
	AST_GAP: assert property (port_valid == (port_num < 4'hE
		&& port_num != gcq_pkg::QUAD_GAP_LO && port_num != gcq_pkg::QUAD_GAP_HI))
		else $error("port existence wrong");
	AST_LOW: assert property (low_swing |=> deemph_level == gcq_pkg::DEEMPH_0DB)
		else $error("low swing de-emphasis not 0 dB");
endmodule // gcq_checker_sva

bind gcq_port_phy gcq_checker_sva u_chk (.clk(clk), .rst(rst), .port_num(port_num),
	.merged_x8(merged_x8), .full_retrain_request(full_retrain_request),
	.retrain_done(retrain_done), .low_swing(low_swing), .ts_valid(ts_valid),
	.ts_sym_idx(ts_sym_idx), .ts_sym_in(ts_sym_in), .ts_sym_out(ts_sym_out),
	.compat_active(compat_active), .retrain_busy(retrain_busy), .quad_sel(quad_sel),
	.port_valid(port_valid), .deemph_level(deemph_level));

// ==== testbench/gcq_link_partner.sv ====
module gcq_link_partner
(
	input  wire logic       clk,       // Core clock
	input  wire logic       rst,       // Async reset
	input  wire logic       rx_valid,  // Symbol valid
	input  wire logic [7:0] rx_sym,    // Symbol received
	output logic [7:0]      sym4_seen  // Symbol 4 of last set
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pos;
	// Sets are sixteen symbols back to back, so position is a plain count
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pos <= 4'h0;
			sym4_seen <= 8'h00;
		end
		else if (rx_valid)
		begin
			pos <= pos + 4'h1;
			if (pos == 4'h4)
				sym4_seen <= rx_sym;
		end
	end
endmodule // gcq_link_partner

// ==== testbench/gcq_port_phy_tb.sv ====
module gcq_port_phy_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, merged, en, req, done, low, sel6, tv, wen, whi, tvo, cact, busy, pv;
	logic [3:0]   pnum, idx;
	logic [7:0]   sym, symo, lsw, seen;
	logic [1:0]   wlane, deemph;
	logic [15:0]  wdata;
	logic [13:0]  qsel;
	logic [127:0] lset;
	int           mismatches = 0;
	int           n_tests = 0;

	gcq_port_phy DUT (.clk(clk), .rst(rst), .port_num(pnum), .merged_x8(merged),
		.legacy_compat_enable(en), .full_retrain_request(req), .retrain_done(done),
		.low_swing(low), .sel_deemph_6db(sel6), .ts_valid(tv), .ts_sym_idx(idx),
		.ts_sym_in(sym), .lane_wr_en(wen), .lane_wr_lane(wlane), .lane_wr_hi_quad(whi),
		.lane_wr_data(wdata), .ts_valid_out(tvo), .ts_sym_out(symo), .compat_active(cact),
		.retrain_busy(busy), .quad_sel(qsel), .port_valid(pv), .deemph_level(deemph),
		.lane_low_swing(lsw), .lane_settings(lset));
	gcq_link_partner u_partner (.clk(clk), .rst(rst), .rx_valid(tvo), .rx_sym(symo),
		.sym4_seen(seen));

	////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	// One whole set, then the partner's copy of symbol 4 is compared
	task automatic send_set(input logic [7:0] s4, input logic [7:0] exp);
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk);
			tv <= 1'b1;
			idx <= i[3:0];
			sym <= (i == 4) ? s4 : 8'h5A;
		end
		@(posedge clk);
		tv <= 1'b0;
		repeat (2) @(negedge clk);
		chk(seen, exp, "symbol 4");
	endtask

	// Retrain with the given enable; done comes only once busy is seen
	task automatic retrain(input logic e);
		int k;
		@(posedge clk);
		en <= e;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		for (k = 0; k < 8 && busy !== 1'b1; k++)
			@(negedge clk);
		if (k == 8)
		begin
			mismatches++;
			final_report();
		end
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		@(negedge clk);
		chk(cact, e, "mode after retrain");
	endtask

	task automatic lane_wr(input logic [1:0] l, input logic h, input logic [15:0] d);
		@(posedge clk);
		wen <= 1'b1;
		wlane <= l;
		whi <= h;
		wdata <= d;
		@(posedge clk);
		wen <= 1'b0;
		repeat (2) @(negedge clk);
		chk(lset[{h, l} * 16 +: 16], d, "lane setting");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Free-running core clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		logic v;
		{rst, merged, en, req, done, low, tv, wen, whi} = 9'h100;
		sel6 = 1'b1;
		{pnum, idx, sym, wlane, wdata} = 34'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(lset, {8{gcq_pkg::DRV_RESET, gcq_pkg::BOOST_RESET, gcq_pkg::DEA_RESET,
			gcq_pkg::SLEW_RESET}}, "lane reset");
		send_set(8'hFF, 8'hFF);
		@(posedge clk);
		en <= 1'b1;
		send_set(8'hFF, 8'hFF);
		retrain(1'b1);
		send_set(8'hFF, 8'hFF & ~gcq_pkg::SYM4_NEW_MASK);
		@(posedge clk);
		en <= 1'b0;
		send_set(8'hFF, 8'hFF & ~gcq_pkg::SYM4_NEW_MASK);
		retrain(1'b0);
		send_set(8'hC4, 8'hC4);
		// Every port number, alone and merged
		for (int p = 0; p < 32; p++)
		begin
			@(posedge clk);
			pnum <= p[3:0];
			merged <= p[4];
			@(posedge clk);
			@(negedge clk);
			v = p[3:0] < 14 && p[3:0] != 10 && p[3:0] != 11;
			chk(pv, v, "port exists");
			chk(qsel, !v ? 14'h0 : (p[4] && !p[0]) ? 14'h3 << p[3:0] : 14'h1 << p[3:0],
				"quad select");
		end
		@(posedge clk);
		pnum <= 4'h4;
		lane_wr(2'h2, 1'b0, 16'hA5C3);
		lane_wr(2'h1, 1'b1, 16'h3C5A);
		@(posedge clk);
		low <= 1'b1;
		repeat (2) @(negedge clk);
		chk(deemph, gcq_pkg::DEEMPH_0DB, "low swing de-emphasis");
		chk(lsw, 8'hFF, "low swing lanes");
		@(posedge clk);
		low <= 1'b0;
		repeat (2) @(negedge clk);
		chk(deemph, gcq_pkg::DEEMPH_6DB, "selected de-emphasis");
		chk(lsw, 8'h00, "full swing lanes");
		@(posedge clk);
		merged <= 1'b0;
		low <= 1'b1;
		repeat (2) @(negedge clk);
		chk(lsw, 8'h0F, "x4 low swing lanes");
		final_report();
	end
endmodule // gcq_port_phy_tb
